// >>> verilog/pmusof_pkg.sv
// Constants and types shared by the sample-record and off-core filter block
// Summary of operation
// - On memory-event counter overflow, latch retiring micro-op address and status for the record.
// - Record word 98H carries the sampled load address or the store destination.
// - Store-status bit 0 is set on a first-level data cache hit of a store event, else cleared.
// - That hit bit is meaningful only for the sampled store event classes.
// - All other store-status bits are written as zero.
// - Record word 0B0H carries the pointer of the retired triggering instruction.
// - Record word 08H carries the pointer of the next instruction after the assist.
// - Configuration bits 15:0 are the request-type mask; its bit must be set.
// - Configuration bits 30:16 are the supplier mask, matched against the response source.
// - Configuration bits 37:31 are the snoop mask, applied with the other two.
// - Request bit 0 selects demand data and page-table reads only.
// - Request bit 1 selects demand ownership reads and prefetch-for-write requests.
// - Request bit 2 selects demand code reads and first-level code prefetches.
// - Request bit 3 selects modified-line write-backs.
// - Request bits 4 to 6 select mid-level prefetch data, ownership and code reads.
// - Request bits 7 to 9 select last-level prefetch data, ownership and code reads.
// - Request bit 10 selects split or uncacheable locked requests.
// - Request bit 11 selects streaming store requests.
// - Request bits 14:12 reserved; bit 15 selects any other uncore-bound request.
// - Supplier bit 16 matches any response; bit 17 matches unknown supplier.
// - Supplier bits 18 to 20 match last-level hits in modified, exclusive, shared.
// - Upper supplier bits follow the product variant; unused ones are reserved.
package pmusof_pkg;

    // Register bus
    localparam int unsigned AXI_AW         = 8;
    localparam logic [7:0]  REG_CFG_LO     = 8'h00;
    localparam logic [7:0]  REG_CFG_HI     = 8'h04;
    localparam logic [7:0]  REG_CTRL       = 8'h08;
    localparam logic [7:0]  REG_STATUS     = 8'h0c;
    localparam logic [7:0]  REG_MATCH_CNT  = 8'h10;
    localparam logic [7:0]  REG_ADDR_LO    = 8'h14;
    localparam logic [7:0]  REG_ADDR_HI    = 8'h18;
    localparam logic [7:0]  REG_STORE_STS  = 8'h1c;
    localparam logic [7:0]  REG_TRIG_LO    = 8'h20;
    localparam logic [7:0]  REG_TRIG_HI    = 8'h24;
    localparam logic [7:0]  REG_NEXT_LO    = 8'h28;
    localparam logic [7:0]  REG_NEXT_HI    = 8'h2c;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Control and status fields
    localparam int unsigned CTRL_SAMPLE_EN = 0;
    localparam int unsigned CTRL_VARIANT   = 1;
    localparam int unsigned STAT_REC_VALID = 0;
    localparam int unsigned STAT_LOST      = 1;
    localparam int unsigned STAT_BUSY      = 2;

    // Precise sample record word offsets
    localparam logic [7:0]  REC_OFS_NEXT_IP = 8'h08;
    localparam logic [7:0]  REC_OFS_ADDR    = 8'h98;
    localparam logic [7:0]  REC_OFS_STS     = 8'ha0;
    localparam logic [7:0]  REC_OFS_RSVD    = 8'ha8;
    localparam logic [7:0]  REC_OFS_TRIG_IP = 8'hb0;
    localparam logic [2:0]  REC_LAST_IDX    = 3'h4;
    localparam int unsigned STS_HIT_BIT     = 0;

    // Off-core match configuration layout
    localparam int unsigned CFG_W       = 38;
    localparam int unsigned CFG_REQ_LSB = 0;
    localparam int unsigned CFG_REQ_MSB = 15;
    localparam int unsigned CFG_SUP_LSB = 16;
    localparam int unsigned CFG_SUP_MSB = 30;
    localparam int unsigned CFG_SNP_LSB = 31;
    localparam int unsigned CFG_SNP_MSB = 37;
    localparam int unsigned REQ_W       = 16;
    localparam int unsigned SUP_W       = 15;
    localparam int unsigned SNP_W       = 7;
    localparam logic [CFG_W-1:0] CFG_RESET = 38'h0;
    // Bits 14:12 reserved
    localparam logic [REQ_W-1:0] REQ_USABLE   = 16'h8fff;
    // Supplier index 0 is the catch-all, others relative to bit 16
    localparam logic [SUP_W-1:0] SUP_USABLE_A = 15'h005e;
    localparam logic [SUP_W-1:0] SUP_USABLE_B = 15'h03de;

    typedef enum logic { PMUSOF_VAR_A, PMUSOF_VAR_B } pmusof_variant_t;
    typedef enum logic { PMUSOF_IDLE, PMUSOF_EMIT } pmusof_state_t;

endpackage

// >>> verilog/pmusof_match.sv
// Off-core response match decode against the configuration masks
`timescale 1ns/1ps
module pmusof_match
    import pmusof_pkg::*;
(
    // Clock and reset, checks only
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // Configuration
    input  wire logic [pmusof_pkg::CFG_W-1:0] cfg,
    input  wire pmusof_pkg::pmusof_variant_t  variant,
    // Transaction
    input  wire logic                         txn_valid,
    input  wire logic [pmusof_pkg::REQ_W-1:0] req_type,
    input  wire logic [pmusof_pkg::SUP_W-1:0] supplier,
    input  wire logic [pmusof_pkg::SNP_W-1:0] snoop,
    // Result
    output logic                              match
);
    logic [SUP_W-1:0] sup_usable;
    logic             req_ok;
    logic             sup_ok;
    logic             snp_ok;

    // Each request class is one bit
    assign req_ok = |(req_type & cfg[CFG_REQ_MSB:CFG_REQ_LSB] & REQ_USABLE);
    // Upper supplier bits depend on the variant
    assign sup_usable = (variant == PMUSOF_VAR_B) ? SUP_USABLE_B : SUP_USABLE_A;
    // Catch-all, unknown and last-level state bits
    assign sup_ok = cfg[CFG_SUP_LSB]
                  | (|(supplier & cfg[CFG_SUP_MSB:CFG_SUP_LSB] & sup_usable));
    assign snp_ok = |(snoop & cfg[CFG_SNP_MSB:CFG_SNP_LSB]);
    assign match  = txn_valid & req_ok & sup_ok & snp_ok;

    default clocking mcb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reserved_req_a: assert property (
        txn_valid && ((req_type & REQ_USABLE) == '0) |-> !match)
        else $error("reserved request bits caused a match");

    any_supplier_a: assert property (
        req_ok && snp_ok && txn_valid && cfg[CFG_SUP_LSB] |-> match)
        else $error("catch-all supplier did not match");

    variant_mask_a: assert property (
        variant == PMUSOF_VAR_A && !cfg[CFG_SUP_LSB]
        && ((supplier & SUP_USABLE_A) == '0) |-> !match)
        else $error("reserved supplier bit matched");

endmodule // pmusof_match

// >>> verilog/pmusof_top.sv
// Precise sample record capture and off-core filter with AXI4-Lite registers
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pmusof_top
    import pmusof_pkg::*;
(
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write
    input  wire logic [pmusof_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read
    input  wire logic [pmusof_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Retirement sample source
    input  wire logic                          ctr_overflow,
    input  wire logic                          ret_valid,
    input  wire logic                          ret_is_mem,
    input  wire logic                          ret_store_evt,
    input  wire logic                          ret_l1_hit,
    input  wire logic [63:0]                   ret_lin_addr,
    input  wire logic [63:0]                   ret_trig_ip,
    input  wire logic [63:0]                   ret_next_ip,
    // Record write port
    output logic                               rec_wr_valid,
    output logic [7:0]                         rec_wr_offset,
    output logic [63:0]                        rec_wr_data,
    // Off-core transactions
    input  wire logic                          txn_valid,
    input  wire logic [pmusof_pkg::REQ_W-1:0]  txn_req_type,
    input  wire logic [pmusof_pkg::SUP_W-1:0]  txn_supplier,
    input  wire logic [pmusof_pkg::SNP_W-1:0]  txn_snoop,
    output logic                               offcore_match
);
    import pmusof_pkg::*;

    logic [CFG_W-1:0]   cfg;
    logic               sample_en;
    pmusof_variant_t    variant;
    logic               rec_valid;
    logic               sample_lost;
    logic [31:0]        match_count;
    logic [63:0]        cap_addr;
    logic [63:0]        cap_trig_ip;
    logic [63:0]        cap_next_ip;
    logic               cap_hit;
    pmusof_state_t      state;
    logic [2:0]         word_idx;
    logic               aw_have;
    logic               w_have;
    logic [AXI_AW-1:0]  aw_addr_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;
    logic               wr_fire;
    logic               wr_ok;
    logic               match_c;
    logic               take;
    logic               overflow_hit;
    logic [31:0]        rd_data_c;
    logic               rd_ok_c;
    logic [31:0]        next_cfg_lo;
    logic [31:0]        next_cfg_hi;
    logic [31:0]        next_ctrl;
    logic [31:0]        status_word;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    pmusof_match u_match (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cfg      (cfg),
        .variant  (variant),
        .txn_valid(txn_valid),
        .req_type (txn_req_type),
        .supplier (txn_supplier),
        .snoop    (txn_snoop),
        .match    (match_c)
    );

    // Bus write path
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign wr_ok   = (aw_addr_q == REG_CFG_LO) || (aw_addr_q == REG_CFG_HI)
                  || (aw_addr_q == REG_CTRL) || (aw_addr_q == REG_STATUS);
    assign next_cfg_lo = merge(cfg[31:0], w_data_q, w_strb_q);
    assign next_cfg_hi = merge({26'h0, cfg[CFG_W-1:32]}, w_data_q, w_strb_q);
    assign next_ctrl   = merge({30'h0, variant, sample_en}, w_data_q, w_strb_q);
    assign status_word = {29'h0, state == PMUSOF_EMIT, sample_lost, rec_valid};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have       <= 1'b0;
            aw_addr_q     <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have       <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end else if (!aw_have && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have       <= 1'b0;
            w_data_q     <= '0;
            w_strb_q     <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have       <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end else if (!w_have && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Match configuration and control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg       <= CFG_RESET;
            sample_en <= 1'b0;
            variant   <= PMUSOF_VAR_A;
        end else if (wr_fire) begin
            unique case (aw_addr_q)
                REG_CFG_LO: cfg[31:0]      <= next_cfg_lo;
                REG_CFG_HI: cfg[CFG_W-1:32] <= next_cfg_hi[CFG_W-33:0];
                REG_CTRL: begin
                    sample_en <= next_ctrl[CTRL_SAMPLE_EN];
                    variant   <= pmusof_variant_t'(next_ctrl[CTRL_VARIANT]);
                end
                default: ;
            endcase
        end
    end

    // Bus read path
    always_comb begin
        rd_ok_c = 1'b1;
        unique case (s_axi_araddr)
            REG_CFG_LO:    rd_data_c = cfg[31:0];
            REG_CFG_HI:    rd_data_c = {26'h0, cfg[CFG_W-1:32]};
            REG_CTRL:      rd_data_c = {30'h0, variant, sample_en};
            REG_STATUS:    rd_data_c = status_word;
            REG_MATCH_CNT: rd_data_c = match_count;
            REG_ADDR_LO:   rd_data_c = cap_addr[31:0];
            REG_ADDR_HI:   rd_data_c = cap_addr[63:32];
            REG_STORE_STS: rd_data_c = {31'h0, cap_hit};
            REG_TRIG_LO:   rd_data_c = cap_trig_ip[31:0];
            REG_TRIG_HI:   rd_data_c = cap_trig_ip[63:32];
            REG_NEXT_LO:   rd_data_c = cap_next_ip[31:0];
            REG_NEXT_HI:   rd_data_c = cap_next_ip[63:32];
            default: begin
                rd_data_c = 32'h0;
                rd_ok_c   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data_c;
            s_axi_rresp   <= rd_ok_c ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Sample capture; one record at a time, overflows during emission set the sticky lost flag
    assign overflow_hit = sample_en && ctr_overflow && ret_valid && ret_is_mem;
    assign take         = overflow_hit && state == PMUSOF_IDLE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_addr    <= '0;
            cap_trig_ip <= '0;
            cap_next_ip <= '0;
            cap_hit     <= 1'b0;
        end else if (take) begin
            cap_addr    <= ret_lin_addr;
            cap_trig_ip <= ret_trig_ip;
            cap_next_ip <= ret_next_ip;
            // Hit only has meaning for store event classes
            cap_hit     <= ret_store_evt && ret_l1_hit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= PMUSOF_IDLE;
            word_idx <= '0;
        end else begin
            unique case (state)
                PMUSOF_IDLE: begin
                    word_idx <= '0;
                    if (take) begin
                        state <= PMUSOF_EMIT;
                    end
                end
                PMUSOF_EMIT: begin
                    word_idx <= word_idx + 3'h1;
                    if (word_idx == REC_LAST_IDX) begin
                        state <= PMUSOF_IDLE;
                    end
                end
            endcase
        end
    end

    // Record words go out one per cycle in a fixed order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rec_wr_valid  <= 1'b0;
            rec_wr_offset <= '0;
            rec_wr_data   <= '0;
        end else begin
            rec_wr_valid <= state == PMUSOF_EMIT;
            unique case (word_idx)
                3'h0: begin
                    rec_wr_offset <= REC_OFS_NEXT_IP;
                    rec_wr_data   <= cap_next_ip;
                end
                3'h1: begin
                    rec_wr_offset <= REC_OFS_ADDR;
                    rec_wr_data   <= cap_addr;
                end
                3'h2: begin
                    rec_wr_offset <= REC_OFS_STS;
                    rec_wr_data   <= {63'h0, cap_hit};
                end
                3'h3: begin
                    rec_wr_offset <= REC_OFS_RSVD;
                    rec_wr_data   <= '0;
                end
                default: begin
                    rec_wr_offset <= REC_OFS_TRIG_IP;
                    rec_wr_data   <= cap_trig_ip;
                end
            endcase
        end
    end

    // Sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rec_valid   <= 1'b0;
            sample_lost <= 1'b0;
        end else begin
            if (state == PMUSOF_EMIT && word_idx == REC_LAST_IDX) begin
                rec_valid <= 1'b1;
            end else if (wr_fire && aw_addr_q == REG_STATUS && w_strb_q[0]
                         && w_data_q[STAT_REC_VALID]) begin
                rec_valid <= 1'b0;
            end
            if (overflow_hit && state != PMUSOF_IDLE) begin
                sample_lost <= 1'b1;
            end else if (wr_fire && aw_addr_q == REG_STATUS && w_strb_q[0]
                         && w_data_q[STAT_LOST]) begin
                sample_lost <= 1'b0;
            end
        end
    end

    // Off-core match pulse and running count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            offcore_match <= 1'b0;
            match_count   <= '0;
        end else begin
            offcore_match <= match_c;
            if (match_c) begin
                match_count <= match_count + 32'h1;
            end
        end
    end

    default clocking tcb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rec_words_s;
        rec_wr_valid && rec_wr_offset == REC_OFS_NEXT_IP
        ##1 rec_wr_valid && rec_wr_offset == REC_OFS_ADDR
        ##1 rec_wr_valid && rec_wr_offset == REC_OFS_STS
        ##1 rec_wr_valid && rec_wr_offset == REC_OFS_RSVD
        ##1 rec_wr_valid && rec_wr_offset == REC_OFS_TRIG_IP
        ##1 !rec_wr_valid;
    endsequence

    write_resp_a: assert property (
        wr_fire |=> s_axi_bvalid && s_axi_bresp == ($past(wr_ok) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response missing");

    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not returned");

    capture_addr_a: assert property (
        take |=> cap_addr == $past(ret_lin_addr) && cap_trig_ip == $past(ret_trig_ip))
        else $error("sample address not latched");

    record_order_a: assert property (
        take |=> ##1 rec_words_s)
        else $error("record words out of order");

    store_status_a: assert property (
        rec_wr_valid && rec_wr_offset == REC_OFS_STS
        |-> rec_wr_data == {63'h0, cap_hit})
        else $error("store status word malformed");

    hit_only_store_a: assert property (
        take && !(ret_store_evt && ret_l1_hit) |=> !cap_hit)
        else $error("hit bit set outside store hit");

    trig_ip_a: assert property (
        rec_wr_valid && rec_wr_offset == REC_OFS_TRIG_IP |-> rec_wr_data == cap_trig_ip)
        else $error("trigger pointer word wrong");

    next_ip_a: assert property (
        take ##2 rec_wr_valid |-> rec_wr_data == $past(ret_next_ip, 2))
        else $error("next pointer word wrong");

    match_pulse_a: assert property (
        match_c |=> offcore_match)
        else $error("match pulse missing");

endmodule // pmusof_top

// >>> tb/pmusof_core_model.sv
// Retirement and off-core traffic source standing in for the core
`timescale 1ns/1ps
module pmusof_core_model (
    // Clock
    input  wire logic aclk,
    // Retirement
    output logic        ctr_overflow,
    output logic        ret_valid,
    output logic        ret_is_mem,
    output logic        ret_store_evt,
    output logic        ret_l1_hit,
    output logic [63:0] ret_lin_addr,
    output logic [63:0] ret_trig_ip,
    output logic [63:0] ret_next_ip,
    // Off-core traffic
    output logic        txn_valid,
    output logic [15:0] txn_req_type,
    output logic [14:0] txn_supplier,
    output logic [6:0]  txn_snoop
);
    initial begin
        {ctr_overflow, ret_valid, ret_is_mem, ret_store_evt, ret_l1_hit, txn_valid} = '0;
        {ret_lin_addr, ret_trig_ip, ret_next_ip} = '0;
        {txn_req_type, txn_supplier, txn_snoop} = '0;
    end
    // Idle payload is inverted so a stale value never looks valid
    task automatic retire(input logic st, hit, input logic [63:0] a, t, n);
        @(posedge aclk);
        {ctr_overflow, ret_valid, ret_is_mem, ret_store_evt, ret_l1_hit} <= {3'h7, st, hit};
        {ret_lin_addr, ret_trig_ip, ret_next_ip} <= {a, t, n};
        @(posedge aclk);
        {ctr_overflow, ret_valid, ret_is_mem, ret_store_evt, ret_l1_hit} <= '0;
        {ret_lin_addr, ret_trig_ip, ret_next_ip} <= ~{a, t, n};
    endtask
    task automatic offcore(input logic [15:0] r, input logic [14:0] s, input logic [6:0] p);
        @(posedge aclk);
        {txn_valid, txn_req_type, txn_supplier, txn_snoop} <= {1'b1, r, s, p};
        @(posedge aclk);
        {txn_valid, txn_req_type, txn_supplier, txn_snoop} <= {1'b0, ~r, ~s, ~p};
    endtask
endmodule // pmusof_core_model

// >>> tb/pmu_sample_offcore_filter_tb_top.sv
// Self-checking bench for the sample-record and off-core filter block
`timescale 1ns/1ps
module pmu_sample_offcore_filter_tb_top;
    import pmusof_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, ctr_overflow, ret_valid, ret_is_mem, ret_store_evt, ret_l1_hit;
    logic        rec_wr_valid, txn_valid, offcore_match;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rec_wr_offset;
    logic [31:0] s_axi_wdata, s_axi_rdata, rq;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [63:0] ret_lin_addr, ret_trig_ip, ret_next_ip, rec_wr_data;
    logic [15:0] txn_req_type;
    logic [14:0] txn_supplier;
    logic [6:0]  txn_snoop;
    logic [63:0] rec_q[$];
    logic [7:0]  ofs_q[$];
    int          num_errors, n_checks, i, v;
    pmusof_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctr_overflow, .ret_valid, .ret_is_mem,
        .ret_store_evt, .ret_l1_hit, .ret_lin_addr, .ret_trig_ip, .ret_next_ip, .rec_wr_valid,
        .rec_wr_offset, .rec_wr_data, .txn_valid, .txn_req_type, .txn_supplier, .txn_snoop,
        .offcore_match);
    pmusof_core_model i_core (.aclk, .ctr_overflow, .ret_valid, .ret_is_mem, .ret_store_evt,
        .ret_l1_hit, .ret_lin_addr, .ret_trig_ip, .ret_next_ip, .txn_valid, .txn_req_type,
        .txn_supplier, .txn_snoop);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rec_wr_valid === 1'b1) begin
            rec_q.push_back(rec_wr_data);
            ofs_q.push_back(rec_wr_offset);
        end
    end
    task automatic chk(input string n, input logic [63:0] e, s);
        n_checks++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Write or read; waits on the handshakes only, the watchdog cuts a hang
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (wr) begin
            {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        end else begin
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        end
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                rr = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_rready && s_axi_rvalid) begin
                {rq, rr} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rec_chk(input logic [63:0] a, t, n, input logic h);
        logic [63:0] d[5];
        logic [7:0]  o[5];
        d = '{n, a, {63'h0, h}, 64'h0, t};
        o = '{8'h08, 8'h98, 8'ha0, 8'ha8, 8'hb0};
        chk("rec count", 64'd5, 64'(rec_q.size()));
        for (int k = 0; k < 5 && k < rec_q.size(); k++) begin
            chk("rec offset", 64'(o[k]), 64'(ofs_q[k]));
            chk("rec data", d[k], rec_q[k]);
        end
        rec_q.delete();
        ofs_q.delete();
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        end_sim();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi(0, REG_CFG_LO, 0);
        chk("cfg reset", 64'h0, 64'(rq));
        axi(0, 8'h30, 0);
        chk("unmapped resp", 64'(RESP_SLVERR), 64'(rr));
        axi(1, REG_CFG_HI, 32'h3f);
        chk("cfg hi resp", 64'(RESP_OKAY), 64'(rr));
        axi(1, REG_MATCH_CNT, 0);
        chk("ro write resp", 64'(RESP_SLVERR), 64'(rr));
        axi(0, REG_CFG_HI, 0);
        chk("cfg hi", 64'h3f, 64'(rq));
        axi(1, REG_CFG_LO, 32'hffffffff);
        for (i = 0; i < 16; i++) begin
            i_core.offcore(16'(1 << i), 15'h2, 7'h1);
            #1 chk("req bit", 64'(REQ_USABLE[i]),
                64'(offcore_match));
        end
        for (v = 0; v < 2; v++) begin
            axi(1, REG_CTRL, 32'(v << 1));
            for (i = 0; i < 15; i++) begin
                axi(1, REG_CFG_LO, {1'b1, 15'(1 << i), 16'h1});
                i_core.offcore(16'h1, 15'(1 << i), 7'h1);
                #1 chk("sup bit", 64'((i == 0) | (v ? SUP_USABLE_B[i] : SUP_USABLE_A[i])),
                    64'(offcore_match));
            end
        end
        axi(1, REG_CFG_LO, 32'h0001_0001);
        i_core.offcore(16'h1, 15'h4000, 7'h1);
        #1 chk("snoop miss", 64'h0, 64'(offcore_match));
        axi(1, REG_CTRL, 32'h1);
        i_core.retire(1, 1, 64'h1234_5678_9abc_def0, 64'h40_1000, 64'h40_1004);
        repeat (10) @(posedge aclk);
        rec_chk(64'h1234_5678_9abc_def0, 64'h40_1000, 64'h40_1004, 1);
        i_core.retire(0, 1, 64'h0fed_cba9_8765_4321, 64'h50_2000, 64'h50_2008);
        repeat (10) @(posedge aclk);
        rec_chk(64'h0fed_cba9_8765_4321, 64'h50_2000, 64'h50_2008, 0);
        axi(0, REG_ADDR_LO, 0);
        chk("addr lo", 64'h8765_4321, 64'(rq));
        axi(0, REG_STATUS, 0);
        chk("status", 64'h1, 64'(rq));
        axi(0, REG_MATCH_CNT, 0);
        chk("match count", 64'h1c, 64'(rq));
        end_sim();
    end
endmodule // pmu_sample_offcore_filter_tb_top
